// ==== logic/flash_program_erase_control.sv ====
`timescale 1ns/1ps
// Function
// - The trigger bit is set only while write permit is 1 and the unlock keys were just written.
// - Setting the trigger starts the selected operation and hardware clears it at completion.
// - Only the write permit and trigger bits return to their reset values on device reset.
// - Write permit enables trigger writes and the low voltage detector; 0 disables both.
// - The operation failure flag is set when a sequence fails and is read only.
// - The low voltage failure flag is set when low supply is seen while programming.
// - The low voltage live bit follows the active low voltage event while enabled.
// - The operation select field is writable only while write permit is 0.
// - Code 0101 erases the whole array only if no page is write protected.
// - Code 0100 erases the addressed page unless it is write protected.
// - Code 0011 programs the addressed row unless it is write protected.
// - Code 0001 programs the addressed word unless it is write protected.
// - Codes 0010 and 0110 do nothing; 0111 to 1111 are reserved.
// - Triggering code 0000 clears the failure and low voltage flags.
// - Bits 31 to 16 and 10 to 4 of the control register read 0 and ignore writes.
module flash_program_erase_control #(
  parameter int pages = flash_ctrl_pkg::array_pages
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        por,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Flash array
  output logic [3:0]       array_op,
  output logic [31:0]      array_target,
  output logic             array_start,
  input  wire logic        array_done,
  input  wire logic        array_error,
  // Supply monitor pin
  input  wire logic        low_supply_pin,
  output logic             detector_enable
);

  typedef struct packed
  {
    flash_ctrl_pkg::seq_state_type seq;
    logic                          trigger;
    logic                          permit;
    logic                          op_fail;
    logic                          lv_fail;
    logic [3:0]                    op_sel;
    logic [31:0]                   target;
    logic [31:0]                   protect;
    logic                          lv_seen;
    logic                          rd_valid;
    logic [31:0]                   rdata;
    logic                          start;
  } ctrl_regs_type;

  ctrl_regs_type r_q;
  ctrl_regs_type r_d;

  flash_ctrl_pkg::bus_req_type req;
  logic                        armed;
  logic                        lv_live;
  logic                        key_wr;
  logic                        ctrl_wr;
  logic                        other_wr;
  logic                        consume;
  logic                        busy;
  logic                        blocked;
  logic                        any_rst;
  logic                        target_wr;
  logic                        protect_wr;
  logic                        lv_hit;
  logic [31:0]                 ctrl_view;

  // True when the bus writes the register at word index a in this cycle.
  function automatic logic write_to(input flash_ctrl_pkg::bus_req_type r, input logic [3:0] a);
    write_to = r.write && (r.address == a);
  endfunction : write_to

  // Pages beyond the array are never protected.
  function automatic logic page_protected(input logic [31:0] prot, input logic [31:0] addr);
    logic [31:0] idx;
    idx = addr >> flash_ctrl_pkg::page_shift;
    page_protected = (idx < 32'(pages)) ? prot[idx[4:0]] : 1'b0;
  endfunction : page_protected

  assign req.address   = avs_address;
  assign req.read      = avs_read;
  assign req.write     = avs_write;
  assign req.writedata = avs_writedata;

  // Either reset clears the key sequencer and the synchroniser, so power-up never starts armed.
  assign any_rst    = rst | por;
  assign busy       = r_q.seq != flash_ctrl_pkg::seq_idle;
  assign key_wr     = write_to(req, flash_ctrl_pkg::addr_key);
  assign ctrl_wr    = write_to(req, flash_ctrl_pkg::addr_control);
  assign target_wr  = write_to(req, flash_ctrl_pkg::addr_target);
  assign protect_wr = write_to(req, flash_ctrl_pkg::addr_protect);
  assign other_wr   = req.write && !key_wr;
  // A low supply seen at any time during the operation fails it.
  assign lv_hit     = r_q.lv_seen || lv_live;
  // The trigger may rise only with permit set, keys armed and no operation running.
  assign consume  = ctrl_wr && req.writedata[flash_ctrl_pkg::trigger_bit] && r_q.permit
                    && armed && !busy;

  unlock_keys #(
    .window(flash_ctrl_pkg::key_window_cycles)
  ) keys (
    .ref_clk    (ref_clk),
    .rst        (any_rst),
    .key_write  (key_wr),
    .key_data   (req.writedata),
    .other_write(other_wr),
    .consume    (consume),
    .armed      (armed)
  );

  // The detector runs only while write permit is set.
  low_voltage_sync low_voltage_detector (
    .ref_clk       (ref_clk),
    .rst           (any_rst),
    .enable        (r_q.permit),
    .low_supply_pin(low_supply_pin),
    .low_live      (lv_live)
  );

  always_comb
  begin
    // Unimplemented bit positions stay zero because the view starts from zero.
    ctrl_view = 32'h0000_0000;
    ctrl_view[flash_ctrl_pkg::trigger_bit]      = r_q.trigger;
    ctrl_view[flash_ctrl_pkg::write_permit_bit] = r_q.permit;
    ctrl_view[flash_ctrl_pkg::op_fail_bit]      = r_q.op_fail;
    ctrl_view[flash_ctrl_pkg::lv_fail_bit]      = r_q.lv_fail;
    ctrl_view[flash_ctrl_pkg::lv_live_bit]      = lv_live;
    ctrl_view[3:0]                              = r_q.op_sel;
  end

  // Protection check for the chosen operation.
  always_comb
  begin
    case (r_q.op_sel)
      flash_ctrl_pkg::op_array_erase:  blocked = r_q.protect != 32'h0000_0000;
      flash_ctrl_pkg::op_page_erase:   blocked = page_protected(r_q.protect, r_q.target);
      flash_ctrl_pkg::op_row_program:  blocked = page_protected(r_q.protect, r_q.target);
      flash_ctrl_pkg::op_word_program: blocked = page_protected(r_q.protect, r_q.target);
      default:                         blocked = 1'b0;
    endcase
  end

  always_comb
  begin
    r_d       = r_q;
    r_d.start = 1'b0;
    r_d.rd_valid = 1'b0;
    // A read loads its data at the first edge and is answered at the second.
    if (req.read && !r_q.rd_valid)
    begin
      r_d.rd_valid = 1'b1;
      case (req.address)
        flash_ctrl_pkg::addr_control: r_d.rdata = ctrl_view;
        flash_ctrl_pkg::addr_target:  r_d.rdata = r_q.target;
        flash_ctrl_pkg::addr_protect: r_d.rdata = r_q.protect;
        default:                      r_d.rdata = 32'h0000_0000;
      endcase
    end
    if (ctrl_wr)
    begin
      r_d.permit = req.writedata[flash_ctrl_pkg::write_permit_bit];
      if (!r_q.permit && !busy)
      begin
        r_d.op_sel = req.writedata[3:0];
      end
    end
    if (target_wr && !busy)
    begin
      r_d.target = req.writedata;
    end
    // Bit n of the protect register guards page n of the array.
    if (protect_wr)
    begin
      r_d.protect = req.writedata;
    end
    if (busy && lv_live)
    begin
      r_d.lv_seen = 1'b1;
    end
    // Sequencer: idle, one cycle to check protection, then wait for the array.
    case (r_q.seq)
      flash_ctrl_pkg::seq_idle:
      begin
        if (consume)
        begin
          r_d.trigger = 1'b1;
          // A new operation forgets any low supply seen before it.
          r_d.lv_seen = 1'b0;
          r_d.seq     = flash_ctrl_pkg::seq_start;
        end
      end
      flash_ctrl_pkg::seq_start:
      begin
        case (r_q.op_sel)
          flash_ctrl_pkg::op_word_program, flash_ctrl_pkg::op_row_program,
          flash_ctrl_pkg::op_page_erase, flash_ctrl_pkg::op_array_erase:
          begin
            // A protected target fails at once and never reaches the array.
            if (blocked)
            begin
              r_d.op_fail = 1'b1;
              r_d.trigger = 1'b0;
              r_d.seq     = flash_ctrl_pkg::seq_idle;
            end
            else
            begin
              r_d.start = 1'b1;
              r_d.seq   = flash_ctrl_pkg::seq_wait;
            end
          end
          flash_ctrl_pkg::op_none_a:
          begin
            r_d.op_fail = 1'b0;
            r_d.lv_fail = 1'b0;
            r_d.trigger = 1'b0;
            r_d.seq     = flash_ctrl_pkg::seq_idle;
          end
          default:
          begin
            r_d.trigger = 1'b0;
            r_d.seq     = flash_ctrl_pkg::seq_idle;
          end
        endcase
      end
      flash_ctrl_pkg::seq_wait:
      begin
        // In the wait state the trigger clears only when the array reports completion.
        if (array_done)
        begin
          r_d.trigger = 1'b0;
          r_d.seq     = flash_ctrl_pkg::seq_idle;
          if (array_error || lv_hit)
          begin
            r_d.op_fail = 1'b1;
          end
          if (lv_hit)
          begin
            r_d.lv_fail = 1'b1;
          end
        end
      end
      default:
      begin
        r_d.seq = flash_ctrl_pkg::seq_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    // Power-on reset clears every register.
    if (por)
    begin
      r_q.seq      <= flash_ctrl_pkg::seq_idle;
      r_q.trigger  <= 1'b0;
      r_q.permit   <= 1'b0;
      r_q.op_fail  <= 1'b0;
      r_q.lv_fail  <= 1'b0;
      r_q.op_sel   <= 4'h0;
      r_q.target   <= flash_ctrl_pkg::target_reset;
      r_q.protect  <= flash_ctrl_pkg::protect_reset;
      r_q.lv_seen  <= 1'b0;
      r_q.rd_valid <= 1'b0;
      r_q.rdata    <= 32'h0000_0000;
      r_q.start    <= 1'b0;
    end
    else if (rst)
    begin
      // Device reset touches only the permit and trigger bits, the sequencing state and the read handshake.
      r_q          <= r_d;
      r_q.permit   <= 1'b0;
      r_q.seq      <= flash_ctrl_pkg::seq_idle;
      r_q.trigger  <= 1'b0;
      r_q.start    <= 1'b0;
      r_q.rd_valid <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Writes never wait; a read waits one cycle for its registered data.
  assign avs_waitrequest = req.read && !r_q.rd_valid;
  assign avs_readdata    = r_q.rdata;
  assign array_op        = r_q.op_sel;
  assign array_target    = r_q.target;
  assign array_start     = r_q.start;
  assign detector_enable = r_q.permit;

endmodule : flash_program_erase_control

// ==== common/flash_ctrl_pkg.sv ====
package flash_ctrl_pkg;

  localparam logic [3:0]  addr_control     = 4'h0;
  localparam logic [3:0]  addr_key         = 4'h1;
  localparam logic [3:0]  addr_target      = 4'h2;
  localparam logic [3:0]  addr_protect     = 4'h3;

  localparam int          trigger_bit      = 15;
  localparam int          write_permit_bit = 14;
  localparam int          op_fail_bit      = 13;
  localparam int          lv_fail_bit      = 12;
  localparam int          lv_live_bit      = 11;
  localparam int          op_sel_lsb       = 0;
  localparam int          op_sel_width     = 4;

  localparam logic [3:0]  op_none_a        = 4'h0;
  localparam logic [3:0]  op_word_program  = 4'h1;
  localparam logic [3:0]  op_none_b        = 4'h2;
  localparam logic [3:0]  op_row_program   = 4'h3;
  localparam logic [3:0]  op_page_erase    = 4'h4;
  localparam logic [3:0]  op_array_erase   = 4'h5;
  localparam logic [3:0]  op_none_c        = 4'h6;

  localparam logic [31:0] key_first        = 32'haa99_6655;
  localparam logic [31:0] key_second       = 32'h5566_99aa;
  localparam logic [31:0] control_reset    = 32'h0000_0000;
  localparam logic [31:0] target_reset     = 32'h0000_0000;
  localparam logic [31:0] protect_reset    = 32'h0000_0000;

  localparam int          key_window_cycles = 8;
  localparam int          read_wait_cycles  = 1;
  localparam int          array_pages       = 32;
  localparam int          page_shift        = 10;

  typedef enum logic [1:0] {key_idle, key_half, key_armed} key_state_type;
  typedef enum logic [1:0] {seq_idle, seq_start, seq_wait} seq_state_type;

  typedef struct packed
  {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } bus_req_type;

  typedef struct packed
  {
    logic [3:0]  op;
    logic [31:0] target;
    logic        start;
  } array_cmd_type;

endpackage : flash_ctrl_pkg

// ==== logic/unlock_keys.sv ====
`timescale 1ns/1ps
module unlock_keys #(
  parameter int window = flash_ctrl_pkg::key_window_cycles
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Key writes
  input  wire logic        key_write,
  input  wire logic [31:0] key_data,
  input  wire logic        other_write,
  input  wire logic        consume,
  // Result
  output logic             armed
);

  typedef struct packed
  {
    flash_ctrl_pkg::key_state_type state;
    logic [7:0]                    count;
  } key_regs_type;

  key_regs_type r_q;
  key_regs_type r_d;

  always_comb
  begin
    r_d = r_q;
    if (r_q.state != flash_ctrl_pkg::key_idle && r_q.count != 8'h00)
    begin
      r_d.count = r_q.count - 8'h01;
    end
    case (r_q.state)
      flash_ctrl_pkg::key_idle:
      begin
        if (key_write && key_data == flash_ctrl_pkg::key_first)
        begin
          r_d.state = flash_ctrl_pkg::key_half;
          r_d.count = 8'(window);
        end
      end
      flash_ctrl_pkg::key_half:
      begin
        // A wrong key, another write or a late key disarms the sequence.
        if (key_write && key_data == flash_ctrl_pkg::key_second && r_q.count != 8'h00)
        begin
          r_d.state = flash_ctrl_pkg::key_armed;
          r_d.count = 8'(window);
        end
        else if (key_write || other_write || r_q.count == 8'h00)
        begin
          r_d.state = flash_ctrl_pkg::key_idle;
        end
      end
      flash_ctrl_pkg::key_armed:
      begin
        if (consume || key_write || r_q.count == 8'h00)
        begin
          r_d.state = flash_ctrl_pkg::key_idle;
        end
      end
      default:
      begin
        r_d.state = flash_ctrl_pkg::key_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q.state <= flash_ctrl_pkg::key_idle;
      r_q.count <= 8'h00;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign armed = (r_q.state == flash_ctrl_pkg::key_armed) && (r_q.count != 8'h00);

endmodule : unlock_keys

// ==== logic/low_voltage_sync.sv ====
`timescale 1ns/1ps
module low_voltage_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Detector
  input  wire logic enable,
  input  wire logic low_supply_pin,
  output logic      low_live
);

  typedef struct packed
  {
    logic meta;
    logic sync;
  } sync_regs_type;

  sync_regs_type r_q;
  sync_regs_type r_d;

  always_comb
  begin
    r_d.meta = low_supply_pin;
    r_d.sync = r_q.meta;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // The detector output is gated off while it is disabled.
  assign low_live = enable & r_q.sync;

endmodule : low_voltage_sync

// ==== dv/flash_array_model.sv ====
`timescale 1ns/1ps
module flash_array_model (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // Command from the sequencer
  input  wire flash_ctrl_pkg::array_cmd_type cmd,
  // Behaviour chosen by the bench
  input  wire logic [7:0]                    delay,
  input  wire logic                          fail,
  // Answer
  output logic                               done,
  output logic                               error
);
  logic [7:0] cnt_q;
  logic       busy_q;

  // The error line only means something alongside done, so it toggles otherwise.
  always_ff @(posedge ref_clk)
  begin
    done  <= 1'b0;
    error <= ~error;
    if (rst)
      busy_q <= 1'b0;
    else if (cmd.start)
    begin
      busy_q <= 1'b1;
      cnt_q  <= delay;
    end
    else if (busy_q && cnt_q == 8'h00)
    begin
      busy_q <= 1'b0;
      done   <= 1'b1;
      error  <= fail;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule : flash_array_model

// ==== dv/flash_program_erase_control_properties.sv ====
`timescale 1ns/1ps
module flash_program_erase_control_properties (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        por,
  // Register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Array side
  input  wire logic [3:0]  array_op,
  input  wire logic [31:0] array_target,
  input  wire logic        array_start,
  input  wire logic        detector_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || por);
  wire ctrl_wr = avs_write && avs_address == flash_ctrl_pkg::addr_control;

  a_permit_follows: assert property (
    ctrl_wr |=> detector_enable == $past(avs_writedata[14])) else $error("permit mismatch");
  a_opsel_locked: assert property (
    ctrl_wr && detector_enable |=> $stable(array_op)) else $error("select changed");
  a_start_pulse: assert property (
    array_start |=> !array_start) else $error("start longer than one cycle");
  a_start_permit: assert property (
    array_start |-> $past(detector_enable)) else $error("start without permit");
  a_op_held: assert property (
    array_start |=> $stable(array_op)) else $error("select moved while busy");
  a_target_held: assert property (
    array_start |=> $stable(array_target)) else $error("target moved while busy");
  a_unused_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == flash_ctrl_pkg::addr_control
      |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[10:4] == 7'h00)
    else $error("unused bits not zero");
  a_read_wait: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
  a_permit_reset: assert property (
    @(posedge ref_clk) disable iff (por) rst |=> !detector_enable)
    else $error("permit kept over reset");
endmodule : flash_program_erase_control_properties

bind flash_program_erase_control flash_program_erase_control_properties
  flash_program_erase_control_properties_i (.ref_clk(ref_clk), .rst(rst), .por(por),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .array_op(array_op), .array_target(array_target),
  .array_start(array_start), .detector_enable(detector_enable));

// ==== dv/flash_program_erase_control_tb_top.sv ====
`timescale 1ns/1ps
module flash_program_erase_control_tb_top;
  typedef struct packed {logic [3:0] op; logic [31:0] prot; logic err, start, fail;} row_type;
  localparam logic [3:0] ctrl = flash_ctrl_pkg::addr_control;
  localparam logic [3:0] key  = flash_ctrl_pkg::addr_key;
  logic                          ref_clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          por = 1'b1;
  logic                          low_supply_pin = 1'b0;
  logic                          fail = 1'b0;
  logic [7:0]                    delay = 8'h03;
  logic                          done;
  logic                          error;
  logic                          wait_w;
  logic                          detector_enable;
  logic [31:0]                   readdata_w;
  logic [31:0]                   rdata;
  flash_ctrl_pkg::bus_req_type   req = '0;
  wire flash_ctrl_pkg::array_cmd_type cmd;
  int                            n_fail = 0;
  int                            n_tests = 0;
  int                            n_start = 0;
  int                            s0;
  row_type rows[15] = '{'{4'h1, 32'h0, 1'b0, 1'b1, 1'b0}, '{4'h3, 32'h0, 1'b0, 1'b1, 1'b0},
    '{4'h4, 32'h0, 1'b0, 1'b1, 1'b0}, '{4'h5, 32'h0, 1'b0, 1'b1, 1'b0},
    '{4'h2, 32'h0, 1'b0, 1'b0, 1'b0}, '{4'h6, 32'h0, 1'b0, 1'b0, 1'b0},
    '{4'h7, 32'h0, 1'b0, 1'b0, 1'b0}, '{4'hf, 32'h0, 1'b0, 1'b0, 1'b0},
    '{4'h1, 32'h2, 1'b0, 1'b1, 1'b0}, '{4'h4, 32'h1, 1'b0, 1'b0, 1'b1},
    '{4'h0, 32'h0, 1'b0, 1'b0, 1'b0}, '{4'h5, 32'h8000_0000, 1'b0, 1'b0, 1'b1},
    '{4'h0, 32'h0, 1'b0, 1'b0, 1'b0}, '{4'h1, 32'h0, 1'b1, 1'b1, 1'b1},
    '{4'h0, 32'h0, 1'b0, 1'b0, 1'b0}};

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cmd.start === 1'b1) n_start <= n_start + 1;

  flash_program_erase_control #(.pages(32)) flash_program_erase_control_i (
    .ref_clk(ref_clk), .rst(rst), .por(por), .avs_address(req.address),
    .avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
    .avs_readdata(readdata_w), .avs_waitrequest(wait_w), .array_op(cmd.op),
    .array_target(cmd.target), .array_start(cmd.start), .array_done(done),
    .array_error(error), .low_supply_pin(low_supply_pin), .detector_enable(detector_enable));

  flash_array_model flash_array_model_i (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
    .delay(delay), .fail(fail), .done(done), .error(error));

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer; the request stands until waitrequest is seen low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (wait_w === 1'b0) break;
    end
    rdata = readdata_w;
    req <= '0;
    if (i == 20)
    begin
      n_fail++;
      finish_test;
    end
  endtask : bus

  task unlock;
    bus(1'b1, key, flash_ctrl_pkg::key_first);
    bus(1'b1, key, flash_ctrl_pkg::key_second);
  endtask : unlock

  // Selects an operation, arms, triggers and polls until the trigger clears.
  task run(input logic [3:0] op);
    int i;
    bus(1'b1, ctrl, {28'h0, op});
    bus(1'b1, ctrl, {20'h4, 8'h00, op});
    unlock;
    bus(1'b1, ctrl, {20'hc, 8'h00, op});
    for (i = 0; i < 60; i++)
    begin
      bus(1'b0, ctrl, 32'h0);
      if (rdata[15] === 1'b0) break;
    end
    if (i == 60)
    begin
      n_fail++;
      finish_test;
    end
  endtask : run

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0);
    foreach (rows[k])
    begin
      bus(1'b1, flash_ctrl_pkg::addr_protect, rows[k].prot);
      fail <= rows[k].err;
      s0 = n_start;
      run(rows[k].op);
      check(rdata, {16'h0, 2'b01, rows[k].fail, 9'h0, rows[k].op});
      check(n_start - s0, {31'h0, rows[k].start});
      check({28'h0, cmd.op}, {28'h0, rows[k].op});
    end
    bus(1'b1, ctrl, 32'h0);
    bus(1'b1, ctrl, 32'hffff_3fff);
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0000_000f);
    bus(1'b1, ctrl, 32'h0000_c00f);
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0000_400f);
    check({31'h0, detector_enable}, 32'h1);
    bus(1'b1, ctrl, 32'h0000_4003);
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0000_400f);
    s0 = n_start;
    bus(1'b1, ctrl, 32'h0000_0001);
    bus(1'b1, ctrl, 32'h0000_4001);
    bus(1'b1, key, flash_ctrl_pkg::key_first);
    bus(1'b1, key, 32'h1234_5678);
    bus(1'b1, key, flash_ctrl_pkg::key_second);
    bus(1'b1, ctrl, 32'h0000_c001);
    bus(1'b1, key, flash_ctrl_pkg::key_first);
    bus(1'b1, flash_ctrl_pkg::addr_target, 32'h0);
    bus(1'b1, key, flash_ctrl_pkg::key_second);
    bus(1'b1, ctrl, 32'h0000_c001);
    repeat (10) @(posedge ref_clk);
    check(n_start - s0, 32'h0);
    delay <= 8'h28;
    unlock;
    bus(1'b1, ctrl, 32'h0000_c001);
    bus(1'b1, flash_ctrl_pkg::addr_target, 32'h0000_0400);
    repeat (4) @(posedge ref_clk);
    check(cmd.target, 32'h0);
    check({28'h0, cmd.op}, 32'h1);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    delay <= 8'h03;
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0000_0001);
    check(n_start - s0, 32'h1);
    fail <= 1'b0;
    low_supply_pin <= 1'b1;
    run(4'h1);
    check(rdata, 32'h0000_7801);
    low_supply_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0000_7001);
    run(4'h0);
    check(rdata, 32'h0000_4000);
    bus(1'b1, ctrl, 32'h0);
    low_supply_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ctrl, 32'h0);
    check(rdata, 32'h0);
    finish_test;
  end
endmodule : flash_program_erase_control_tb_top
